// *** hdl/mies_pkg.sv ***
// shared constants, opcodes and carriers of the execute subset
`default_nettype none
package mies_pkg;
  // ------------------------------------------------------------
  // widths and timing
  // ------------------------------------------------------------
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned PC_W       = 11;
  localparam int unsigned WB_ADR_W   = 8;
  localparam int unsigned WB_DAT_W   = 32;
  localparam int unsigned WD_PRE_W   = 8;
  localparam int unsigned WD_CNT_W   = 8;
  localparam logic [3:0]  BCD_LIMIT  = 4'h9;
  localparam logic [4:0]  BCD_ADJUST = 5'h06;
  // ------------------------------------------------------------
  // register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] ADR_ACC    = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] ADR_CTRL   = 8'h08;
  localparam logic [7:0] ADR_WATCH  = 8'h0C;
  // status and control fields
  localparam int unsigned ST_CARRY   = 0;
  localparam int unsigned ST_AUX     = 1;
  localparam int unsigned ST_ZERO    = 2;
  localparam int unsigned ST_OVFL    = 3;
  localparam int unsigned ST_PWRDN   = 4;
  localparam int unsigned ST_TIMEOUT = 5;
  localparam int unsigned CT_GIE     = 0;
  // reset values
  localparam logic [7:0] ACC_RST    = 8'h00;
  localparam logic       FLAG_RST   = 1'b0;
  // ------------------------------------------------------------
  // operations
  // ------------------------------------------------------------
  typedef enum logic [4:0] {
    OP_NOP        = 5'h00, OP_CLR_BYTE   = 5'h01, OP_CLR_BIT    = 5'h02,
    OP_WD_CLEAR   = 5'h03, OP_WD_PRE1    = 5'h04, OP_WD_PRE2    = 5'h05,
    OP_INVERT     = 5'h06, OP_INVERT_ACC = 5'h07, OP_DEC_ADJ    = 5'h08,
    OP_DEC        = 5'h09, OP_DEC_ACC    = 5'h0A, OP_INC        = 5'h0B,
    OP_INC_ACC    = 5'h0C, OP_HALT       = 5'h0D, OP_JUMP       = 5'h0E,
    OP_MOV_IMM    = 5'h0F, OP_MOV_TO_ACC = 5'h10, OP_MOV_TO_MEM = 5'h11,
    OP_OR_MEM     = 5'h12, OP_OR_IMM     = 5'h13, OP_OR_TO_MEM  = 5'h14,
    OP_RET        = 5'h15, OP_RET_IMM    = 5'h16, OP_INT_RET    = 5'h17,
    OP_ROT_LEFT   = 5'h18
  } mies_op_e;

  typedef enum logic [1:0] {
    S_RUN  = 2'b00,
    S_RET2 = 2'b01,
    S_HALT = 2'b10
  } mies_state_e;

  typedef struct packed {
    mies_op_e         op;
    logic [2:0]       bit_sel;
    logic [7:0]       imm;
    logic [PC_W-1:0]  target;
  } mies_instr_s;

  typedef struct packed {
    logic             we;
    logic [7:0]       data;
  } mies_mem_wr_s;
endpackage : mies_pkg
`default_nettype wire

// *** hdl/mies_exec.sv ***
// execute stage of the small 8-bit core for the listed instruction subset
//
// Register access over Wishbone and the register offsets were left to the implementer.
`default_nettype none
module mies_exec #(
  parameter int unsigned PRE_W = mies_pkg::WD_PRE_W,
  parameter int unsigned CNT_W = mies_pkg::WD_CNT_W
) (
  // clock and reset
  input  wire logic                          ref_clk,
  input  wire logic                          rst,
  input  wire logic                          clk_en,
  // wishbone slave
  input  wire logic                          wb_cyc_i,
  input  wire logic                          wb_stb_i,
  input  wire logic                          wb_we_i,
  input  wire logic [mies_pkg::WB_ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                    wb_sel_i,
  input  wire logic [mies_pkg::WB_DAT_W-1:0] wb_dat_i,
  output logic      [mies_pkg::WB_DAT_W-1:0] wb_dat_o,
  output logic                               wb_ack_o,
  // instruction issue
  input  wire logic                          instr_valid,
  input  wire mies_pkg::mies_instr_s         instr,
  output logic                               instr_ready,
  // data memory operand and write-back
  input  wire logic [7:0]                    mem_rdata,
  output mies_pkg::mies_mem_wr_s             mem_wr,
  // program counter and return stack
  input  wire logic [mies_pkg::PC_W-1:0]     stack_top,
  output logic                               stack_pop,
  output logic                               pc_step,
  output logic                               pc_load,
  output logic      [mies_pkg::PC_W-1:0]     pc_target,
  // power control and interrupt enable
  input  wire logic                          wake_req,
  output logic                               sys_clk_gate_en,
  output logic                               global_interrupt_enable
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  mies_pkg::mies_state_e state;
  mies_pkg::mies_state_e next_state;
  logic [7:0]       acc;
  logic             carry_flag;
  logic             aux_carry_flag;
  logic             zero_flag;
  logic             overflow_flag;
  logic             power_down_flag;
  logic             timeout_flag;
  logic             pre1_seen;
  logic             pre2_seen;
  logic [PRE_W-1:0] watchdog_prescaler;
  logic [CNT_W-1:0] watchdog_counter;

  logic       fire;
  logic       acc_we;
  logic [7:0] next_acc;
  logic       mem_we;
  logic [7:0] next_mem;
  logic       zero_we;
  logic [7:0] zero_src;
  logic       carry_we;
  logic       next_carry;
  logic       wd_clear;
  logic       wd_pre_done;
  logic       internal_nibble_carry;
  logic [4:0] lo_sum;
  logic [4:0] hi_sum;
  logic       wd_tick;
  logic       wd_wrap;
  logic       bus_wr;

  assign instr_ready     = (state == mies_pkg::S_RUN);
  assign fire            = clk_en & instr_valid & instr_ready;
  assign sys_clk_gate_en = (state != mies_pkg::S_HALT);
  assign bus_wr          = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;

  // ------------------------------------------------------------
  // decimal adjust datapath
  // ------------------------------------------------------------
  always_comb begin
    if ((acc[3:0] > mies_pkg::BCD_LIMIT) || aux_carry_flag) begin
      lo_sum = {1'b0, acc[3:0]} + mies_pkg::BCD_ADJUST;
    end else begin
      lo_sum = {1'b0, acc[3:0]};
    end
    internal_nibble_carry = lo_sum[4];
    hi_sum = {1'b0, acc[7:4]} + {4'h0, internal_nibble_carry};
    if ((hi_sum > {1'b0, mies_pkg::BCD_LIMIT}) || carry_flag) begin
      hi_sum = hi_sum + mies_pkg::BCD_ADJUST;
    end
  end

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  always_comb begin
    acc_we      = 1'b0;
    next_acc    = acc;
    mem_we      = 1'b0;
    next_mem    = mem_rdata;
    zero_we     = 1'b0;
    zero_src    = 8'h00;
    carry_we    = 1'b0;
    next_carry  = carry_flag;
    wd_clear    = 1'b0;
    wd_pre_done = 1'b0;
    next_state  = state;
    case (state)
      mies_pkg::S_RUN: begin
        if (fire) begin
          case (instr.op)
            mies_pkg::OP_CLR_BYTE: begin
              mem_we   = 1'b1;
              next_mem = 8'h00;
            end
            mies_pkg::OP_CLR_BIT: begin
              mem_we   = 1'b1;
              next_mem = mem_rdata & ~(8'h01 << instr.bit_sel);
            end
            mies_pkg::OP_WD_CLEAR: begin
              wd_clear = 1'b1;
            end
            mies_pkg::OP_WD_PRE1: begin
              wd_pre_done = pre2_seen;
            end
            mies_pkg::OP_WD_PRE2: begin
              wd_pre_done = pre1_seen;
            end
            mies_pkg::OP_INVERT: begin
              mem_we   = 1'b1;
              next_mem = ~mem_rdata;
              zero_we  = 1'b1;
              zero_src = ~mem_rdata;
            end
            mies_pkg::OP_INVERT_ACC: begin
              acc_we   = 1'b1;
              next_acc = ~mem_rdata;
              zero_we  = 1'b1;
              zero_src = ~mem_rdata;
            end
            mies_pkg::OP_DEC_ADJ: begin
              mem_we     = 1'b1;
              next_mem   = {hi_sum[3:0], lo_sum[3:0]};
              carry_we   = 1'b1;
              next_carry = (hi_sum > {1'b0, mies_pkg::BCD_LIMIT}) | carry_flag;
            end
            mies_pkg::OP_DEC, mies_pkg::OP_DEC_ACC: begin
              zero_we  = 1'b1;
              zero_src = mem_rdata - 8'h01;
              if (instr.op == mies_pkg::OP_DEC) begin
                mem_we   = 1'b1;
                next_mem = mem_rdata - 8'h01;
              end else begin
                acc_we   = 1'b1;
                next_acc = mem_rdata - 8'h01;
              end
            end
            mies_pkg::OP_INC, mies_pkg::OP_INC_ACC: begin
              zero_we  = 1'b1;
              zero_src = mem_rdata + 8'h01;
              if (instr.op == mies_pkg::OP_INC) begin
                mem_we   = 1'b1;
                next_mem = mem_rdata + 8'h01;
              end else begin
                acc_we   = 1'b1;
                next_acc = mem_rdata + 8'h01;
              end
            end
            mies_pkg::OP_HALT: begin
              next_state = mies_pkg::S_HALT;
            end
            mies_pkg::OP_MOV_IMM: begin
              acc_we   = 1'b1;
              next_acc = instr.imm;
            end
            mies_pkg::OP_MOV_TO_ACC: begin
              acc_we   = 1'b1;
              next_acc = mem_rdata;
            end
            mies_pkg::OP_MOV_TO_MEM: begin
              mem_we   = 1'b1;
              next_mem = acc;
            end
            mies_pkg::OP_OR_MEM, mies_pkg::OP_OR_IMM: begin
              acc_we   = 1'b1;
              next_acc = acc | ((instr.op == mies_pkg::OP_OR_IMM) ? instr.imm : mem_rdata);
              zero_we  = 1'b1;
              zero_src = next_acc;
            end
            mies_pkg::OP_OR_TO_MEM: begin
              mem_we   = 1'b1;
              next_mem = acc | mem_rdata;
              zero_we  = 1'b1;
              zero_src = acc | mem_rdata;
            end
            mies_pkg::OP_RET, mies_pkg::OP_RET_IMM, mies_pkg::OP_INT_RET: begin
              next_state = mies_pkg::S_RET2;
              if (instr.op == mies_pkg::OP_RET_IMM) begin
                acc_we   = 1'b1;
                next_acc = instr.imm;
              end
            end
            mies_pkg::OP_ROT_LEFT: begin
              mem_we   = 1'b1;
              next_mem = {mem_rdata[6:0], mem_rdata[7]};
            end
            default: begin
              // no-op and jump touch no data
            end
          endcase
        end
      end
      mies_pkg::S_RET2: begin
        if (clk_en) begin
          next_state = mies_pkg::S_RUN;
        end
      end
      mies_pkg::S_HALT: begin
        if (clk_en && wake_req) begin
          next_state = mies_pkg::S_RUN;
        end
      end
      default: begin
        next_state = mies_pkg::S_RUN;
      end
    endcase
  end

  // ------------------------------------------------------------
  // sequencing and program counter
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= mies_pkg::S_RUN;
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  // return target is read from the stack while the pop still stands
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stack_pop <= 1'b0;
      pc_step   <= 1'b0;
      pc_load   <= 1'b0;
      pc_target <= '0;
    end else if (clk_en) begin
      stack_pop <= fire & (next_state == mies_pkg::S_RET2);
      pc_step   <= fire & (instr.op != mies_pkg::OP_JUMP)
                        & (next_state != mies_pkg::S_RET2);
      pc_load   <= 1'b0;
      if (fire && instr.op == mies_pkg::OP_JUMP) begin
        pc_load   <= 1'b1;
        pc_target <= instr.target;
      end
      if (state == mies_pkg::S_RET2) begin
        pc_load   <= 1'b1;
        pc_target <= stack_top;
      end
    end
  end

  // ------------------------------------------------------------
  // accumulator, flags and memory write-back
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      acc <= mies_pkg::ACC_RST;
    end else if (clk_en) begin
      if (acc_we) begin
        acc <= next_acc;
      end else if (bus_wr && wb_adr_i == mies_pkg::ADR_ACC && wb_sel_i[0]) begin
        acc <= wb_dat_i[7:0];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      carry_flag     <= mies_pkg::FLAG_RST;
      aux_carry_flag <= mies_pkg::FLAG_RST;
      zero_flag      <= mies_pkg::FLAG_RST;
      overflow_flag  <= mies_pkg::FLAG_RST;
    end else if (clk_en) begin
      if (bus_wr && wb_adr_i == mies_pkg::ADR_STATUS && wb_sel_i[0]) begin
        carry_flag     <= wb_dat_i[mies_pkg::ST_CARRY];
        aux_carry_flag <= wb_dat_i[mies_pkg::ST_AUX];
        zero_flag      <= wb_dat_i[mies_pkg::ST_ZERO];
        overflow_flag  <= wb_dat_i[mies_pkg::ST_OVFL];
      end
      // instruction results win over a software write
      if (zero_we) begin
        zero_flag <= (zero_src == 8'h00);
      end
      if (carry_we) begin
        carry_flag <= next_carry;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mem_wr <= '0;
    end else if (clk_en) begin
      mem_wr.we   <= mem_we;
      mem_wr.data <= next_mem;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      global_interrupt_enable <= 1'b0;
    end else if (clk_en) begin
      if (fire && instr.op == mies_pkg::OP_INT_RET) begin
        global_interrupt_enable <= 1'b1;
      end else if (bus_wr && wb_adr_i == mies_pkg::ADR_CTRL && wb_sel_i[0]) begin
        global_interrupt_enable <= wb_dat_i[mies_pkg::CT_GIE];
      end
    end
  end

  // ------------------------------------------------------------
  // watchdog
  // ------------------------------------------------------------
  assign wd_tick = &watchdog_prescaler;
  assign wd_wrap = wd_tick & (&watchdog_counter);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pre1_seen <= 1'b0;
      pre2_seen <= 1'b0;
    end else if (clk_en) begin
      if (wd_pre_done) begin
        pre1_seen <= 1'b0;
        pre2_seen <= 1'b0;
      end else if (fire && instr.op == mies_pkg::OP_WD_PRE1) begin
        pre1_seen <= 1'b1;
      end else if (fire && instr.op == mies_pkg::OP_WD_PRE2) begin
        pre2_seen <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      watchdog_prescaler <= '0;
      watchdog_counter   <= '0;
      power_down_flag    <= 1'b0;
      timeout_flag       <= 1'b0;
    end else if (clk_en) begin
      watchdog_prescaler <= watchdog_prescaler + 1'b1;
      if (wd_tick) begin
        watchdog_counter <= watchdog_counter + 1'b1;
      end
      if (wd_clear || wd_pre_done) begin
        watchdog_counter <= '0;
        power_down_flag  <= 1'b0;
        timeout_flag     <= 1'b0;
      end
      if (fire && instr.op == mies_pkg::OP_HALT) begin
        watchdog_prescaler <= '0;
        watchdog_counter   <= '0;
        power_down_flag    <= 1'b1;
        timeout_flag       <= 1'b0;
      end
      // an expiry in the clearing cycle is still reported
      if (wd_wrap) begin
        timeout_flag <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // wishbone slave: one wait state, unmapped reads return zero
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else if (clk_en) begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      wb_dat_o <= '0;
      case (wb_adr_i)
        mies_pkg::ADR_ACC:    wb_dat_o[7:0] <= acc;
        mies_pkg::ADR_STATUS: wb_dat_o[5:0] <= {timeout_flag, power_down_flag, overflow_flag,
                                                zero_flag, aux_carry_flag, carry_flag};
        mies_pkg::ADR_CTRL:   wb_dat_o[0] <= global_interrupt_enable;
        mies_pkg::ADR_WATCH:  wb_dat_o[CNT_W-1:0] <= watchdog_counter;
        default:              wb_dat_o <= '0;
      endcase
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence issued(mies_pkg::mies_op_e o);
    fire && instr.op == o;
  endsequence

  bit_clear_a: assert property (issued(mies_pkg::OP_CLR_BIT) |=> mem_wr.we
    && mem_wr.data == ($past(mem_rdata) & ~(8'h01 << $past(instr.bit_sel)))
    && $stable(zero_flag) && $stable(carry_flag))
    else $error("bit clear wrong");
  byte_clear_a: assert property (issued(mies_pkg::OP_CLR_BYTE) |=> mem_wr.we
    && mem_wr.data == 8'h00 && $stable(zero_flag))
    else $error("byte clear wrong");
  wd_clear_a: assert property (issued(mies_pkg::OP_WD_CLEAR) ##0 !wd_wrap |=>
    !power_down_flag && !timeout_flag && watchdog_counter == '0)
    else $error("watchdog clear wrong");
  pre_single_a: assert property (issued(mies_pkg::OP_WD_PRE1) ##0 !pre2_seen |=>
    $stable(power_down_flag) && pre1_seen)
    else $error("single pre-clear acted");
  invert_mem_a: assert property (issued(mies_pkg::OP_INVERT) |=> mem_wr.we
    && mem_wr.data == ~$past(mem_rdata) && zero_flag == (mem_wr.data == 8'h00))
    else $error("invert wrong");
  invert_acc_a: assert property (issued(mies_pkg::OP_INVERT_ACC) |=> !mem_wr.we
    && acc == ~$past(mem_rdata)) else $error("invert to acc wrong");
  dec_adj_a: assert property (issued(mies_pkg::OP_DEC_ADJ) ##0 carry_flag |=>
    carry_flag && $stable(zero_flag)) else $error("adjust lost carry");
  inc_acc_a: assert property (issued(mies_pkg::OP_INC_ACC) |=> !mem_wr.we
    && acc == $past(mem_rdata) + 8'h01) else $error("increment to acc wrong");
  halt_flags_a: assert property (issued(mies_pkg::OP_HALT) ##0 !wd_wrap |=>
    power_down_flag && !timeout_flag && !sys_clk_gate_en && pc_step)
    else $error("halt wrong");
  ret_two_a: assert property (issued(mies_pkg::OP_RET) |=> stack_pop && !pc_load
    && !instr_ready ##1 pc_load && instr_ready) else $error("return timing wrong");
  int_ret_a: assert property (issued(mies_pkg::OP_INT_RET) |=>
    global_interrupt_enable) else $error("interrupt enable not set");
  rot_left_a: assert property (issued(mies_pkg::OP_ROT_LEFT) |=> mem_wr.we
    && mem_wr.data == {$past(mem_rdata[6:0]), $past(mem_rdata[7])})
    else $error("rotate wrong");
endmodule : mies_exec
`default_nettype wire

// *** verification/mies_mem_model.sv ***
// data memory operand and return stack model facing the execute stage
`default_nettype none
module mies_mem_model (
  // clock
  input  wire logic                      ref_clk,
  // bench preload
  input  wire logic                      load_en,
  input  wire logic [7:0]                load_val,
  input  wire logic [mies_pkg::PC_W-1:0] ret_addr,
  // execute stage side
  input  wire mies_pkg::mies_mem_wr_s    mem_wr,
  input  wire logic                      stack_pop,
  output logic      [7:0]                mem_rdata,
  output logic      [mies_pkg::PC_W-1:0] stack_top
);
  timeunit 1ns;
  timeprecision 1ns;
  logic pop_d;
  always_ff @(posedge ref_clk) begin
    pop_d <= stack_pop;
    if (load_en)
      mem_rdata <= load_val;
    else if (mem_wr.we)
      mem_rdata <= mem_wr.data;
  end
  // top only valid around a pop; garbled otherwise so stale reads show
  assign stack_top = (stack_pop || pop_d) ? ret_addr : ~ret_addr;
endmodule : mies_mem_model
`default_nettype wire

// *** verification/tb_mcu_instruction_execute_subset.sv ***
// self-checking bench of the execute subset
`default_nettype none
module tb_mcu_instruction_execute_subset;
  timeunit 1ns;
  timeprecision 1ns;
  logic                   ref_clk = 1'b0;
  logic                   rst     = 1'b1;
  logic                   cyc     = 1'b0;
  logic                   we      = 1'b0;
  logic                   iv      = 1'b0;
  logic                   wake    = 1'b0;
  logic                   en      = 1'b1;
  logic                   ld      = 1'b0;
  logic [7:0]             adr     = 8'h00;
  logic [7:0]             lval    = 8'h00;
  logic [31:0]            wdat    = 32'h0;
  logic [10:0]            ret     = 11'h2A5;
  mies_pkg::mies_instr_s  ins     = '0;
  mies_pkg::mies_mem_wr_s mwr;
  logic [31:0]            dat_o, rdat;
  logic                   ack, rdy, pop, step, load, gate, gie;
  logic                   c_step, c_load, c_pop, c_rdy, l2;
  logic [7:0]             mem;
  logic [10:0]            stop, tgt, c_tgt, t2;
  int                     n_fail  = 0;
  int                     checks  = 0;

  always #25 ref_clk = ~ref_clk;

  mies_exec dut (
    .ref_clk(ref_clk), .rst(rst), .clk_en(en), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .instr_valid(iv), .instr(ins), .instr_ready(rdy), .mem_rdata(mem),
    .mem_wr(mwr), .stack_top(stop), .stack_pop(pop), .pc_step(step), .pc_load(load),
    .pc_target(tgt), .wake_req(wake), .sys_clk_gate_en(gate), .global_interrupt_enable(gie)
  );
  mies_mem_model partner (
    .ref_clk(ref_clk), .load_en(ld), .load_val(lval), .ret_addr(ret), .mem_wr(mwr),
    .stack_pop(pop), .mem_rdata(mem), .stack_top(stop)
  );

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do @(posedge ref_clk); while (ack !== 1'b1);
    rdat = dat_o;
    cyc  <= 1'b0;
    we   <= 1'b0;
    @(posedge ref_clk);
  endtask : wb

  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask : rc

  task automatic lm(input logic [7:0] v);
    ld   <= 1'b1;
    lval <= v;
    @(posedge ref_clk);
    ld   <= 1'b0;
  endtask : lm

  // snapshots the answer cycle and the one after it
  task automatic ex(input mies_pkg::mies_op_e op, input logic [7:0] imm = 8'h00,
                    input logic [10:0] tg = 11'h0);
    ins <= '{op: op, bit_sel: 3'h1, imm: imm, target: tg};
    iv  <= 1'b1;
    do @(posedge ref_clk); while (rdy !== 1'b1);
    iv  <= 1'b0;
    #1;
    {c_step, c_load, c_pop, c_rdy, c_tgt} = {step, load, pop, rdy, tgt};
    @(posedge ref_clk);
    #1;
    {l2, t2} = {load, tgt};
    @(posedge ref_clk);
  endtask : ex

  task automatic halt_wake();
    ex(mies_pkg::OP_HALT);
    chk(c_step, 1'b1);
    chk({gate, rdy}, 2'b00);
    rc(mies_pkg::ADR_STATUS, 32'h12);
    rc(mies_pkg::ADR_WATCH, 32'h0);
    wake <= 1'b1;
    @(posedge ref_clk);
    wake <= 1'b0;
  endtask : halt_wake

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    repeat (5000) @(posedge ref_clk);
    n_fail++;
    wrap_up();
  end

  initial begin
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    rc(mies_pkg::ADR_ACC, 32'h0);
    rc(8'h10, 32'h0);
    wb(1'b1, mies_pkg::ADR_STATUS, 32'h3);
    lm(8'h81);
    ex(mies_pkg::OP_ROT_LEFT);
    chk(mem, 8'h03);
    ex(mies_pkg::OP_CLR_BIT);
    chk(mem, 8'h01);
    rc(mies_pkg::ADR_STATUS, 32'h3);
    lm(8'hFF);
    ex(mies_pkg::OP_INVERT);
    chk(mem, 8'h00);
    rc(mies_pkg::ADR_STATUS, 32'h7);
    ex(mies_pkg::OP_INVERT_ACC);
    chk(mem, 8'h00);
    rc(mies_pkg::ADR_ACC, 32'hFF);
    rc(mies_pkg::ADR_STATUS, 32'h3);
    lm(8'h01);
    ex(mies_pkg::OP_DEC_ACC);
    rc(mies_pkg::ADR_ACC, 32'h0);
    rc(mies_pkg::ADR_STATUS, 32'h7);
    ex(mies_pkg::OP_INC_ACC);
    rc(mies_pkg::ADR_ACC, 32'h2);
    rc(mies_pkg::ADR_STATUS, 32'h3);
    ex(mies_pkg::OP_DEC);
    chk(mem, 8'h00);
    ex(mies_pkg::OP_INC);
    chk(mem, 8'h01);
    ex(mies_pkg::OP_MOV_IMM, 8'h5A);
    rc(mies_pkg::ADR_ACC, 32'h5A);
    ex(mies_pkg::OP_OR_IMM, 8'h0F);
    rc(mies_pkg::ADR_ACC, 32'h5F);
    lm(8'hA0);
    ex(mies_pkg::OP_OR_TO_MEM);
    chk(mem, 8'hFF);
    ex(mies_pkg::OP_OR_MEM);
    rc(mies_pkg::ADR_ACC, 32'hFF);
    lm(8'h3C);
    ex(mies_pkg::OP_MOV_TO_ACC);
    lm(8'h00);
    ex(mies_pkg::OP_MOV_TO_MEM);
    chk(mem, 8'h3C);
    ex(mies_pkg::OP_CLR_BYTE);
    chk(mem, 8'h00);
    rc(mies_pkg::ADR_STATUS, 32'h3);
    ex(mies_pkg::OP_NOP);
    chk({c_step, c_load}, 2'b10);
    rc(mies_pkg::ADR_ACC, 32'h3C);
    wb(1'b1, mies_pkg::ADR_ACC, 32'h9A);
    wb(1'b1, mies_pkg::ADR_STATUS, 32'h0);
    ex(mies_pkg::OP_DEC_ADJ);
    chk(mem, 8'h00);
    rc(mies_pkg::ADR_STATUS, 32'h1);
    wb(1'b1, mies_pkg::ADR_ACC, 32'h12);
    ex(mies_pkg::OP_DEC_ADJ);
    chk(mem, 8'h72);
    rc(mies_pkg::ADR_STATUS, 32'h1);
    wb(1'b1, mies_pkg::ADR_ACC, 32'h23);
    wb(1'b1, mies_pkg::ADR_STATUS, 32'h2);
    ex(mies_pkg::OP_DEC_ADJ);
    chk(mem, 8'h29);
    rc(mies_pkg::ADR_STATUS, 32'h2);
    ex(mies_pkg::OP_JUMP, 8'h00, 11'h5A3);
    chk({c_step, c_load, c_tgt}, {2'b01, 11'h5A3});
    ex(mies_pkg::OP_RET);
    chk({c_pop, c_rdy, l2, t2}, {3'b101, ret});
    ex(mies_pkg::OP_RET_IMM, 8'hC3);
    chk({l2, t2}, {1'b1, ret});
    rc(mies_pkg::ADR_ACC, 32'hC3);
    ex(mies_pkg::OP_INT_RET);
    rc(mies_pkg::ADR_CTRL, 32'h1);
    repeat (300) @(posedge ref_clk);
    halt_wake();
    rc(mies_pkg::ADR_ACC, 32'hC3);
    en  <= 1'b0;
    ins <= '{op: mies_pkg::OP_MOV_IMM, bit_sel: 3'h0, imm: 8'h11, target: 11'h0};
    iv  <= 1'b1;
    repeat (3) @(posedge ref_clk);
    {iv, en} <= 2'b01;
    @(posedge ref_clk);
    chk(step, 1'b0);
    rc(mies_pkg::ADR_ACC, 32'hC3);
    repeat (300) @(posedge ref_clk);
    ex(mies_pkg::OP_WD_CLEAR);
    rc(mies_pkg::ADR_STATUS, 32'h2);
    rc(mies_pkg::ADR_WATCH, 32'h0);
    halt_wake();
    ex(mies_pkg::OP_WD_PRE1);
    ex(mies_pkg::OP_WD_PRE1);
    rc(mies_pkg::ADR_STATUS, 32'h12);
    ex(mies_pkg::OP_WD_PRE2);
    rc(mies_pkg::ADR_STATUS, 32'h2);
    wrap_up();
  end
endmodule : tb_mcu_instruction_execute_subset
`default_nettype wire
